// file: src/tx_packet_queue.sv
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`default_nettype none

// Behaviour
// - Manual mode keeps sent buffers until released
// - Allocate command reserves a buffer for host
// - Allocation-done flag set on success for polling
// - Assigned packet number shown in allocation result
// - Enqueue pushes packet number register into queue
// - Queued packets sent with no host action
// - Send only when enabled and full duplex or deferral allows
// - Status word overwrites first buffer word
// - Sent number moves to completion FIFO unless auto mode frees it on success
// - Transmit interrupt while completion FIFO nonempty
// - Failure raises interrupt, clears enable, stops
// - Failed packet number shown in FIFO ports
// - Selected packet's status readable through data
// - Release command frees the packet's buffer
// - Acknowledge write pops completion FIFO head
// - Auto mode frees pages, flags queue drained
module tx_packet_queue
    import tx_queue_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [BE_W-1:0] avs_byteenable,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // MAC transmit side
    output logic tx_req,
    output logic [PN_W-1:0] tx_pkt,
    input wire logic mac_defer_ok,
    input wire logic mac_done,
    input wire logic mac_ok,
    input wire logic [STAT_W-1:0] mac_status
);

    typedef struct packed {
        bus_st_t bst;
        logic waitrequest;
        logic [DATA_W-1:0] readdata;
        logic transmit_enable_bit;
        logic auto_rel;
        logic fdx;
        logic [PN_W-1:0] pnum;
        logic [PTR_W-1:0] ptr;
        logic alloc_fail;
        logic [PN_W-1:0] alloc_num;
        logic alloc_pend;
        logic allocation_done_flag;
        logic transmit_queue_drained_flag;
        logic [NUM_PKTS-1:0] used;
        logic [NUM_PKTS-1:0][PN_W-1:0] txq;
        logic [PN_W:0] txq_wp;
        logic [PN_W:0] txq_rp;
        logic [NUM_PKTS-1:0][PN_W-1:0] cq;
        logic [PN_W:0] cq_wp;
        logic [PN_W:0] cq_rp;
        tx_st_t tst;
        logic tx_req;
        logic [PN_W-1:0] tx_pkt;
        logic [DATA_W-1:0] tx_status;
        logic tx_ok;
        logic [DATA_W-1:0] link_engine_status;
    } state_t;

    state_t st;
    state_t next_st;

    logic mem_we;
    logic [BE_W-1:0] mem_be;
    logic [MEM_AW-1:0] mem_addr;
    logic [DATA_W-1:0] mem_wdata;
    logic [DATA_W-1:0] mem_rdata;

    logic [PN_W:0] txq_count;
    logic [PN_W:0] cq_count;
    logic txq_empty;
    logic cq_empty;
    logic [PN_W-1:0] txq_head;
    logic [PN_W-1:0] cq_head;

    // Queue occupancy
    assign txq_count = st.txq_wp - st.txq_rp;
    assign cq_count = st.cq_wp - st.cq_rp;
    assign txq_empty = (txq_count == '0);
    assign cq_empty = (cq_count == '0);
    assign txq_head = st.txq[st.txq_rp[PN_W-1:0]];
    assign cq_head = st.cq[st.cq_rp[PN_W-1:0]];

    packet_ram u_ram (
        .ref_clk(ref_clk),
        .we(mem_we),
        .be(mem_be),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // Next state of bus slave, buffer manager, queues and transmit engine
    always_comb
    begin
        logic [DATA_W-1:0] rv;
        logic wb;
        logic txq_push;
        logic txq_pop;
        logic cq_push;
        logic cq_pop;
        logic [PN_W-1:0] cq_in;
        logic [NUM_PKTS-1:0] free_mask;
        logic any_free;
        logic [PN_W-1:0] free_num;
        logic is_data;
        cmd_t cmd;
        rv = '0;
        wb = (st.tst == T_WB);
        txq_push = 1'b0;
        txq_pop = 1'b0;
        cq_push = 1'b0;
        cq_pop = 1'b0;
        cq_in = st.tx_pkt;
        free_mask = '0;
        any_free = 1'b0;
        free_num = '0;
        is_data = (avs_address == OFS_DATA);
        cmd = cmd_t'(avs_writedata[CMD_LSB +: 3]);
        next_st = st;
        mem_we = 1'b0;
        mem_be = '1;
        mem_addr = {st.pnum, st.ptr};
        mem_wdata = avs_writedata;

        // Register read value
        if (avs_address == OFS_CTRL)
        begin
            rv[CTRL_TXEN_BIT] = st.transmit_enable_bit;
            rv[CTRL_AUTO_BIT] = st.auto_rel;
            rv[CTRL_FDX_BIT] = st.fdx;
        end
        else if (avs_address == OFS_ALLOC)
        begin
            rv[ALLOC_FAIL_BIT] = st.alloc_fail;
            rv[PN_W-1:0] = st.alloc_num;
        end
        else if (avs_address == OFS_PNUM)
            rv[PN_W-1:0] = st.pnum;
        else if (avs_address == OFS_PTR)
            rv[PTR_W-1:0] = st.ptr;
        else if (avs_address == OFS_FIFO)
        begin
            rv[FIFO_CQ_LSB +: PN_W] = cq_head;
            rv[FIFO_CQ_EMPTY_BIT] = cq_empty;
            rv[FIFO_TXQ_LSB +: PN_W] = txq_head;
            rv[FIFO_TXQ_EMPTY_BIT] = txq_empty;
        end
        else if (avs_address == OFS_ISTAT)
        begin
            rv[ISTAT_TX_BIT] = !cq_empty;
            rv[ISTAT_ALLOC_BIT] = st.allocation_done_flag;
            rv[ISTAT_DRAIN_BIT] = st.transmit_queue_drained_flag;
        end
        else if (avs_address == OFS_LSTAT)
            rv = st.link_engine_status;

        // Bus slave: status write-back owns the memory port, so data accesses wait
        case (st.bst)
            B_IDLE:
            begin
                if ((avs_read || avs_write) && !(wb && is_data))
                begin
                    next_st.waitrequest = 1'b0;
                    next_st.bst = B_ACK;
                    if (avs_write)
                    begin
                        if (avs_address == OFS_CTRL)
                        begin
                            next_st.transmit_enable_bit = avs_writedata[CTRL_TXEN_BIT];
                            next_st.auto_rel = avs_writedata[CTRL_AUTO_BIT];
                            next_st.fdx = avs_writedata[CTRL_FDX_BIT];
                        end
                        else if (avs_address == OFS_CMD)
                        begin
                            case (cmd)
                                CMD_ALLOC:
                                begin
                                    next_st.allocation_done_flag = 1'b0;
                                    next_st.alloc_fail = 1'b1;
                                    // Oversized requests can never be met
                                    next_st.alloc_pend = (avs_writedata[CMD_CNT_LSB +: CNT_W] <= PAGE_BYTES);
                                end
                                CMD_RESET:
                                begin
                                    next_st.used = '0;
                                    next_st.alloc_pend = 1'b0;
                                    next_st.txq_rp = st.txq_wp;
                                    next_st.cq_rp = st.cq_wp;
                                end
                                CMD_RELEASE:
                                    free_mask[st.pnum] = 1'b1;
                                CMD_ENQUEUE:
                                    txq_push = (txq_count != (PN_W+1)'(NUM_PKTS));
                                default:
                                    txq_push = 1'b0;
                            endcase
                        end
                        else if (avs_address == OFS_PNUM)
                            next_st.pnum = avs_writedata[PN_W-1:0];
                        else if (avs_address == OFS_PTR)
                            next_st.ptr = avs_writedata[PTR_W-1:0];
                        else if (is_data)
                        begin
                            mem_we = 1'b1;
                            mem_be = avs_byteenable;
                            next_st.ptr = st.ptr + 1'b1;
                        end
                        else if (avs_address == OFS_ISTAT)
                        begin
                            // Write one to clear; hardware sets below win
                            if (avs_writedata[ISTAT_ALLOC_BIT])
                                next_st.allocation_done_flag = 1'b0;
                            if (avs_writedata[ISTAT_DRAIN_BIT])
                                next_st.transmit_queue_drained_flag = 1'b0;
                        end
                        else if (avs_address == OFS_TXACK)
                            cq_pop = !cq_empty;
                    end
                    else if (is_data)
                    begin
                        // Memory read data arrive one cycle later
                        next_st.waitrequest = 1'b1;
                        next_st.bst = B_RDMEM;
                        next_st.ptr = st.ptr + 1'b1;
                    end
                    else
                        next_st.readdata = rv;
                end
            end
            B_RDMEM:
            begin
                next_st.readdata = mem_rdata;
                next_st.waitrequest = 1'b0;
                next_st.bst = B_ACK;
            end
            default:
            begin
                next_st.waitrequest = 1'b1;
                next_st.bst = B_IDLE;
            end
        endcase

        // Transmit engine
        case (st.tst)
            T_IDLE:
            begin
                if (!txq_empty && st.transmit_enable_bit && (st.fdx || mac_defer_ok))
                begin
                    next_st.tx_req = 1'b1;
                    next_st.tx_pkt = txq_head;
                    next_st.tst = T_SEND;
                end
            end
            T_SEND:
            begin
                if (mac_done)
                begin
                    next_st.tx_req = 1'b0;
                    next_st.tx_status = {{(DATA_W-STAT_W){1'b0}}, mac_status};
                    next_st.tx_ok = mac_ok;
                    next_st.tst = T_WB;
                end
            end
            T_WB:
            begin
                mem_we = 1'b1;
                mem_be = '1;
                mem_addr = {st.tx_pkt, {PTR_W{1'b0}}};
                mem_wdata = st.tx_status;
                next_st.link_engine_status = st.tx_status;
                txq_pop = !txq_empty;
                if (st.tx_ok && st.auto_rel)
                begin
                    free_mask[st.tx_pkt] = 1'b1;
                    if (txq_count == (PN_W+1)'(1))
                        next_st.transmit_queue_drained_flag = 1'b1;
                end
                else
                    cq_push = 1'b1;
                if (!st.tx_ok)
                    next_st.transmit_enable_bit = 1'b0;
                next_st.tst = T_IDLE;
            end
            default:
                next_st.tst = T_IDLE;
        endcase
        // Buffer manager: release, then grant the lowest free buffer
        next_st.used = next_st.used & ~free_mask;
        for (int i = NUM_PKTS - 1; i >= 0; i--)
        begin
            if (!st.used[i])
            begin
                any_free = 1'b1;
                free_num = PN_W'(i);
            end
        end
        if (next_st.alloc_pend && any_free)
        begin
            next_st.alloc_pend = 1'b0;
            next_st.alloc_fail = 1'b0;
            next_st.alloc_num = free_num;
            next_st.used[free_num] = 1'b1;
            next_st.allocation_done_flag = 1'b1;
        end
        // Queue updates
        if (txq_push)
        begin
            next_st.txq[st.txq_wp[PN_W-1:0]] = st.pnum;
            next_st.txq_wp = st.txq_wp + 1'b1;
        end
        if (txq_pop)
            next_st.txq_rp = st.txq_rp + 1'b1;
        if (cq_push && cq_count != (PN_W+1)'(NUM_PKTS))
        begin
            next_st.cq[st.cq_wp[PN_W-1:0]] = cq_in;
            next_st.cq_wp = st.cq_wp + 1'b1;
        end
        if (cq_pop)
            next_st.cq_rp = st.cq_rp + 1'b1;
    end

    // State register
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            st <= '0;
            st.waitrequest <= 1'b1;
            st.transmit_enable_bit <= TXEN_RST;
            st.auto_rel <= AUTO_RST;
            st.fdx <= FDX_RST;
            st.alloc_fail <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign avs_readdata = st.readdata;
    assign avs_waitrequest = st.waitrequest;
    assign tx_req = st.tx_req;
    assign tx_pkt = st.tx_pkt;

endmodule

`default_nettype wire

// file: include/tx_queue_pkg.sv
`default_nettype none

package tx_queue_pkg;

    // Data path and buffer geometry
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int PN_W = 2;
    localparam int NUM_PKTS = 4;
    localparam int PTR_W = 6;
    localparam int MEM_AW = 8;
    localparam int CNT_W = 11;
    localparam int STAT_W = 16;
    localparam int ADDR_W = 8;
    localparam logic [CNT_W-1:0] PAGE_BYTES = 11'h100;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CMD = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_ALLOC = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PNUM = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_PTR = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_DATA = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_FIFO = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_ISTAT = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_TXACK = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_LSTAT = 8'h24;

    // Field positions
    localparam int CTRL_TXEN_BIT = 0;
    localparam int CTRL_AUTO_BIT = 1;
    localparam int CTRL_FDX_BIT = 2;
    localparam int CMD_LSB = 0;
    localparam int CMD_CNT_LSB = 16;
    localparam int ALLOC_FAIL_BIT = 7;
    localparam int FIFO_CQ_LSB = 0;
    localparam int FIFO_CQ_EMPTY_BIT = 7;
    localparam int FIFO_TXQ_LSB = 8;
    localparam int FIFO_TXQ_EMPTY_BIT = 15;
    localparam int ISTAT_TX_BIT = 0;
    localparam int ISTAT_ALLOC_BIT = 1;
    localparam int ISTAT_DRAIN_BIT = 2;

    // Reset values
    localparam logic TXEN_RST = 1'b0;
    localparam logic AUTO_RST = 1'b0;
    localparam logic FDX_RST = 1'b0;

    // Buffer manager commands
    typedef enum logic [2:0] {
        CMD_NOP = 3'b000,
        CMD_ALLOC = 3'b001,
        CMD_RESET = 3'b010,
        CMD_RELEASE = 3'b011,
        CMD_ENQUEUE = 3'b100
    } cmd_t;

    // Bus slave states
    typedef enum logic [1:0] {
        B_IDLE = 2'b00,
        B_RDMEM = 2'b01,
        B_ACK = 2'b10
    } bus_st_t;

    // Transmit engine states
    typedef enum logic [1:0] {
        T_IDLE = 2'b00,
        T_SEND = 2'b01,
        T_WB = 2'b10
    } tx_st_t;

endpackage

`default_nettype wire

// file: src/packet_ram.sv
`default_nettype none

module packet_ram
    import tx_queue_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Access port
    input wire logic we,
    input wire logic [BE_W-1:0] be,
    input wire logic [MEM_AW-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0] rdata
);

    // One byte-wide array per lane so byte enables need no read-modify-write
    genvar g;
    generate
        for (g = 0; g < BE_W; g++)
        begin : lane
            logic [7:0] bytes [0:(1<<MEM_AW)-1];
            logic [7:0] q;
            always_ff @(posedge ref_clk)
            begin
                if (we && be[g])
                begin
                    bytes[addr] <= wdata[8*g +: 8];
                end
                q <= bytes[addr];
            end
            assign rdata[8*g +: 8] = q;
        end
    endgenerate

endmodule

`default_nettype wire

// file: sim/tx_queue_assertions.sv
`default_nettype none

module tx_queue_assertions
    import tx_queue_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register bus
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [BE_W-1:0] avs_byteenable,
    input wire logic [DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    // MAC side
    input wire logic tx_req,
    input wire logic [PN_W-1:0] tx_pkt,
    input wire logic mac_defer_ok,
    input wire logic mac_done,
    input wire logic mac_ok,
    input wire logic [STAT_W-1:0] mac_status
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] ctrl;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Shadow of control bits: host writes set them, a failed send clears enable
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            ctrl <= 3'h0;
        else if (avs_write && !avs_waitrequest && avs_address == OFS_CTRL)
            ctrl <= avs_writedata[2:0];
        else if (tx_req && mac_done && !mac_ok)
            ctrl[0] <= 1'b0;
    end
    // Bus answers and transmit handshake
    property p_ans_once;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    property p_reg_ans;
        $rose(avs_read || avs_write) && (avs_write || avs_address != OFS_DATA) |-> ##[1:2] !avs_waitrequest;
    endproperty
    property p_data_ans;
        $rose(avs_read) && avs_address == OFS_DATA |-> ##[2:3] !avs_waitrequest;
    endproperty
    property p_hold;
        tx_req && !mac_done |=> tx_req && $stable(tx_pkt);
    endproperty
    property p_drop;
        tx_req && mac_done |=> !tx_req;
    endproperty
    property p_gap;
        $fell(tx_req) |=> !tx_req;
    endproperty
    property p_gate;
        $rose(tx_req) |-> ctrl[0] && ($past(mac_defer_ok) || ctrl[2]);
    endproperty
    property p_ctrl_rd;
        avs_read && !avs_waitrequest && avs_address == OFS_CTRL |-> avs_readdata[2:0] == ctrl;
    endproperty
    a_ans_once: assert property (p_ans_once) else $error("waitrequest low too long");
    a_reg_ans: assert property (p_reg_ans) else $error("register access not answered");
    a_data_ans: assert property (p_data_ans) else $error("data access not answered");
    a_hold: assert property (p_hold) else $error("transmit request dropped early");
    a_drop: assert property (p_drop) else $error("transmit request held after done");
    a_gap: assert property (p_gap) else $error("no write-back cycle after send");
    a_gate: assert property (p_gate) else $error("send started while not allowed");
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");
    // Main scenarios
    c_send: cover property ($rose(tx_req));
    c_fail: cover property (tx_req && mac_done && !mac_ok);
    c_data: cover property (avs_read && !avs_waitrequest && avs_address == OFS_DATA);
endmodule

`default_nettype wire

// file: sim/mac_model.sv
`default_nettype none

module mac_model
    import tx_queue_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Transmit request and test controls
    input wire logic tx_req,
    input wire logic [PN_W-1:0] tx_pkt,
    input wire logic fail,
    input wire logic [3:0] lat,
    // Completion
    output logic mac_done,
    output logic mac_ok,
    output logic [STAT_W-1:0] mac_status
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;
    logic [STAT_W-1:0] stat;
    // Ends each frame after a chosen number of cycles
    always_ff @(posedge ref_clk)
    begin
        if (rst || !tx_req || mac_done)
        begin
            cnt <= 4'h0;
            mac_done <= 1'b0;
        end
        else
        begin
            cnt <= cnt + 4'h1;
            mac_done <= (cnt == lat);
        end
    end
    // Result lines carry junk outside the done pulse
    assign stat = {fail, 7'h2a, 6'h0, tx_pkt};
    assign mac_ok = mac_done ? !fail : fail;
    assign mac_status = mac_done ? stat : ~stat;
endmodule

`default_nettype wire

// file: sim/tb_tx_packet_queue.sv
`default_nettype none

module tb_tx_packet_queue import tx_queue_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [DATA_W-1:0] avs_writedata = '0;
    logic [DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic tx_req;
    logic [PN_W-1:0] tx_pkt;
    logic mac_defer_ok = 1'b0;
    logic mac_done;
    logic mac_ok;
    logic [STAT_W-1:0] mac_status;
    logic fail = 1'b0;
    logic [3:0] lat = 4'h0;
    logic tx_q = 1'b0;
    logic [DATA_W-1:0] rdat;
    logic [PN_W-1:0] pn [4];
    logic [PN_W-1:0] sent [$];
    int fail_count = 0;
    int checked = 0;
    tx_packet_queue dut_u (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tx_req(tx_req), .tx_pkt(tx_pkt),
        .mac_defer_ok(mac_defer_ok), .mac_done(mac_done), .mac_ok(mac_ok), .mac_status(mac_status));
    mac_model mac_u (.ref_clk(ref_clk), .rst(rst), .tx_req(tx_req), .tx_pkt(tx_pkt), .fail(fail), .lat(lat),
        .mac_done(mac_done), .mac_ok(mac_ok), .mac_status(mac_status));
    // Clock
    initial
    begin
        forever #10 ref_clk = ~ref_clk;
    end
    // Log of packet numbers as each send starts
    always @(posedge ref_clk)
    begin
        if (tx_req === 1'b1 && tx_q === 1'b0)
            sent.push_back(tx_pkt);
        tx_q = tx_req;
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    // One bus transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= wd;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 40);
        chk("bus answer", 32'(n < 40), 32'h1);
        rdat = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask
    function automatic logic [31:0] cw(input cmd_t c, input logic [10:0] n);
        return {5'h0, n, 13'h0, c};
    endfunction
    function automatic logic [31:0] st(input logic [PN_W-1:0] p, input logic f);
        return {16'h0, f, 7'h2a, 6'h0, p};
    endfunction
    task automatic poll(input int b);
        int k;
        k = 0;
        do
        begin
            rd(OFS_ISTAT);
            k++;
        end
        while (rdat[b] !== 1'b1 && k < 50);
    endtask
    task automatic enq(input logic [PN_W-1:0] p);
        wr(OFS_PNUM, {30'h0, p});
        wr(OFS_CMD, cw(CMD_ENQUEUE, 11'h0));
    endtask
    task automatic wait_sent(input int n);
        int k;
        k = 0;
        while ((sent.size() < n || tx_req !== 1'b0) && k < 300)
        begin
            @(posedge ref_clk);
            k++;
        end
        repeat (3) @(posedge ref_clk);
    endtask
    // Reset values and an unmapped address
    task automatic t_reset();
        rd(OFS_CTRL);
        chk("ctrl", rdat, 32'h0);
        rd(OFS_ALLOC);
        chk("alloc fail", 32'(rdat[ALLOC_FAIL_BIT]), 32'h1);
        rd(OFS_FIFO);
        chk("fifo", rdat, 32'h8080);
        rd(8'h40);
        chk("unmapped", rdat, 32'h0);
        $display("t_reset done");
    endtask
    // Oversize refusal, four allocations, frame load and readback
    task automatic t_alloc();
        logic [3:0] used;
        used = 4'h0;
        wr(OFS_CMD, cw(CMD_ALLOC, 11'h101));
        repeat (2) rd(OFS_ALLOC);
        chk("oversize", 32'(rdat[ALLOC_FAIL_BIT]), 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS_CMD, cw(CMD_ALLOC, 11'h040));
            poll(ISTAT_ALLOC_BIT);
            chk("alloc done", 32'(rdat[ISTAT_ALLOC_BIT]), 32'h1);
            rd(OFS_ALLOC);
            chk("alloc ok", 32'(rdat[ALLOC_FAIL_BIT]), 32'h0);
            pn[i] = rdat[1:0];
            chk("distinct", 32'(used[pn[i]]), 32'h0);
            used[pn[i]] = 1'b1;
            wr(OFS_PNUM, {30'h0, pn[i]});
            wr(OFS_PTR, 32'h0);
            wr(OFS_DATA, 32'hdead0000 | i);
            wr(OFS_DATA, 32'hbeef0000 | i);
            wr(OFS_PTR, 32'h1);
            rd(OFS_DATA);
            chk("data", rdat, 32'hbeef0000 | i);
        end
        wr(OFS_CMD, cw(CMD_ALLOC, 11'h040));
        $display("t_alloc done");
    endtask
    // Gated sends, status, release and acknowledge
    task automatic t_send();
        enq(pn[0]);
        enq(pn[1]);
        rd(OFS_FIFO);
        chk("txq head", rdat, {16'h0, 6'h0, pn[0], 8'h80});
        wr(OFS_CTRL, 32'h1);
        repeat (10) @(posedge ref_clk);
        chk("deferred", 32'(tx_req), 32'h0);
        mac_defer_ok <= 1'b1;
        wait_sent(2);
        chk("order0", 32'(sent[0]), 32'(pn[0]));
        chk("order1", 32'(sent[1]), 32'(pn[1]));
        rd(OFS_ISTAT);
        chk("tx int", 32'(rdat[ISTAT_TX_BIT]), 32'h1);
        rd(OFS_ALLOC);
        chk("kept", 32'(rdat[ALLOC_FAIL_BIT]), 32'h1);
        rd(OFS_FIFO);
        chk("done head", rdat, {24'h80, 6'h0, pn[0]});
        wr(OFS_PNUM, {30'h0, pn[0]});
        wr(OFS_PTR, 32'h0);
        rd(OFS_DATA);
        chk("status", rdat, st(pn[0], 1'b0));
        wr(OFS_CMD, cw(CMD_RELEASE, 11'h0));
        wr(OFS_TXACK, 32'h0);
        rd(OFS_FIFO);
        chk("next head", 32'(rdat[7:0]), 32'(pn[1]));
        rd(OFS_ALLOC);
        chk("freed", rdat[7:0], {6'h0, pn[0]});
        wr(OFS_TXACK, 32'h0);
        rd(OFS_ISTAT);
        chk("int clear", 32'(rdat[ISTAT_TX_BIT]), 32'h0);
        $display("t_send done");
    endtask
    // Failure stops sending; host re-enables and re-enqueues
    task automatic t_fail();
        fail <= 1'b1;
        lat <= 4'h9;
        enq(pn[1]);
        wait_sent(3);
        rd(OFS_CTRL);
        chk("enable off", 32'(rdat[CTRL_TXEN_BIT]), 32'h0);
        rd(OFS_FIFO);
        chk("fail num", rdat[7:0], {6'h0, pn[1]});
        rd(OFS_LSTAT);
        chk("link stat", rdat, st(pn[1], 1'b1));
        fail <= 1'b0;
        enq(pn[2]);
        repeat (10) @(posedge ref_clk);
        chk("stopped", 32'(sent.size()), 32'h3);
        wr(OFS_TXACK, 32'h0);
        enq(pn[1]);
        wr(OFS_CTRL, 32'h1);
        wait_sent(5);
        chk("resend", 32'(sent[3]), 32'(pn[2]));
        chk("resend2", 32'(sent[4]), 32'(pn[1]));
        $display("t_fail done");
    endtask
    // Auto release in full duplex: buffer freed, queue drained flagged
    task automatic t_auto();
        repeat (2) wr(OFS_TXACK, 32'h0);
        mac_defer_ok <= 1'b0;
        wr(OFS_CTRL, 32'h7);
        enq(pn[3]);
        wait_sent(6);
        chk("fdx send", 32'(sent[5]), 32'(pn[3]));
        rd(OFS_ISTAT);
        chk("drained", rdat, 32'h6);
        wr(OFS_CMD, cw(CMD_ALLOC, 11'h040));
        poll(ISTAT_ALLOC_BIT);
        rd(OFS_ALLOC);
        chk("auto free", rdat[7:0], {6'h0, pn[3]});
        $display("t_auto done");
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #400us;
        fail_count++;
        stop_test();
    end
    // Main sequence
    initial
    begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_alloc();
        t_send();
        t_fail();
        t_auto();
        stop_test();
    end
endmodule

bind tx_packet_queue tx_queue_assertions chk_u (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tx_req(tx_req), .tx_pkt(tx_pkt),
    .mac_defer_ok(mac_defer_ok), .mac_done(mac_done), .mac_ok(mac_ok), .mac_status(mac_status));

`default_nettype wire
